/* bmdi_consts.svh */
// Offsets, field positions and reset values of the diagnostic interrupt block
`ifndef BMDI_CONSTS_SVH
`define BMDI_CONSTS_SVH

`define BMDI_OFS_SUMMARY 4'h8
`define BMDI_OFS_CLASS 4'h9
`define BMDI_OFS_STATE 4'hA
`define BMDI_OFS_MEMORY 4'hB

`define BMDI_B0_GROUP 0
`define BMDI_B0_INT 1
`define BMDI_B0_EXT 2
`define BMDI_B0_MISMATCH 3
`define BMDI_B0_UNDERV 4
`define BMDI_B1_ALWAYS1 4
`define BMDI_B1_IOERR 6
`define BMDI_B2_MISMATCH 0
`define BMDI_B2_OFFLINE 2
`define BMDI_B2_WDOG 3
`define BMDI_B3_EEPROM 2

`define BMDI_CLASS_DEFAULT 4'h5
`define BMDI_RD_IDLE 8'h00

`endif

/* bmdi_pkg.sv */
// Types shared by the diagnostic interrupt block
`default_nettype none
package bmdi_pkg;
  typedef enum logic [1:0] {
    BMDI_IDLE,
    BMDI_PEND
  } bmdi_irq_state_t;

  typedef struct packed {
    logic mismatch;
    logic underv;
    logic eeprom;
    logic wdog;
  } bmdi_cond_t;
endpackage : bmdi_pkg
`default_nettype wire

/* bmdi_cond_if.sv */
// Carrier of filtered condition levels between the block's modules
`default_nettype none
interface bmdi_cond_if;
  bmdi_pkg::bmdi_cond_t cond;
  logic changed;
  modport src (output cond, output changed);
  modport dst (input cond, input changed);
endinterface : bmdi_cond_if
`default_nettype wire

/* bmdi_cond.sv */
// Condition gathering: mode gating of external sources, latched internal faults
`default_nettype none
`include "bmdi_consts.svh"
module bmdi_cond (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_protected_mode,
  input wire logic i_host_restart,
  input wire logic i_slave_mismatch,
  input wire logic i_bus_power_fail,
  input wire logic i_eeprom_error,
  input wire logic i_watchdog_fault,
  bmdi_cond_if.src cond_o
);
  logic eeprom_hold;
  logic wdog_hold;
  bmdi_pkg::bmdi_cond_t prev;
  bmdi_pkg::bmdi_cond_t now_c;

  // External sources only count in protected mode
  assign now_c.mismatch = i_protected_mode & i_slave_mismatch;
  assign now_c.underv = i_protected_mode & i_bus_power_fail;
  // Internal faults stick until host restart, so they only leave after a restart
  assign now_c.eeprom = eeprom_hold | i_eeprom_error;
  assign now_c.wdog = wdog_hold | i_watchdog_fault;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      eeprom_hold <= 1'b0;
      wdog_hold <= 1'b0;
      prev <= '0;
    end else begin
      eeprom_hold <= (eeprom_hold & ~i_host_restart) | i_eeprom_error;
      wdog_hold <= (wdog_hold & ~i_host_restart) | i_watchdog_fault;
      prev <= now_c;
    end
  end

  assign cond_o.cond = now_c;
  assign cond_o.changed = (now_c != prev);
endmodule : bmdi_cond
`default_nettype wire

/* bmdi_delta.sv */
// Per-slave delta list of missing, wrong or unconfigured slaves
`default_nettype none
module bmdi_delta #(
  parameter int N_SLAVES = 64
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [N_SLAVES-1:0] i_expected,
  input wire logic [N_SLAVES-1:0] i_present,
  output logic [N_SLAVES-1:0] o_delta,
  output logic o_any
);
  // Any difference between expected and found slaves marks an error bit
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_delta <= '0;
    end else begin
      o_delta <= i_expected ^ i_present;
    end
  end
  assign o_any = |o_delta;
endmodule : bmdi_delta
`default_nettype wire

/* bmdi_top.sv */
// Diagnostic interrupt logic of the bus master module
// Operation
// - Protected mode: raise interrupt on every bus configuration change incl. undervoltage.
// - Sources: slave change, bus power fail (protected mode), EEPROM error.
// - Return to error-free raises leaving interrupt, group flag 0; else flag 1.
// - Internal faults always entering; group flag held until host restart.
// - Deferred events give one interrupt later, only if state differs.
// - Same state as last signalled when possible again: no interrupt.
// - External events raise interrupts only in protected mode.
// - Host STOP clears interrupt history and all record error flags; offline and slave I/O error bits stay live.
// - Protected to configuration mode clears external interrupt history.
// - Configuration to protected with configuration error raises interrupt.
// - Deferred mode-change interrupt raised only if error persists.
// - Summary flags: group, internal, external, mismatch, undervoltage; top bits zero.
// - Module class: class code bits 0-3, bit 4 one, bits 5,7 reserved.
// - Module class bit 6: slave I/O error when firmware three or later.
// - State flags: bit0 mismatch, bit3 watchdog; bits 1,4-7 zero.
// - State flags bit 2 set while device offline.
// - Memory flags bit 2 defective EEPROM; other bits zero.
// - Continuous per-slave delta list, one marks error.
`default_nettype none
`include "bmdi_consts.svh"
module bmdi_top #(
  parameter int N_SLAVES = 64,
  parameter logic [3:0] MODULE_CLASS = `BMDI_CLASS_DEFAULT, // Arbitrary value
  parameter bit FW_V3 = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_protected_mode,
  input wire logic i_host_run,
  input wire logic i_host_restart,
  input wire logic i_host_ack,
  input wire logic i_offline,
  input wire logic i_bus_power_fail,
  input wire logic i_eeprom_error,
  input wire logic i_watchdog_fault,
  input wire logic i_slave_io_error,
  input wire logic [N_SLAVES-1:0] i_expected,
  input wire logic [N_SLAVES-1:0] i_present,
  input wire logic i_rd,
  input wire logic [3:0] i_addr,
  output logic [7:0] o_rdata,
  output logic o_diag_irq,
  output logic [N_SLAVES-1:0] o_delta_list
);
  // ****************************************************************
  // Sources
  // ****************************************************************
  bmdi_cond_if cif();
  logic [N_SLAVES-1:0] delta;
  logic any_mismatch;

  bmdi_delta #(.N_SLAVES(N_SLAVES)) u_delta (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_expected(i_expected),
    .i_present(i_present),
    .o_delta(delta),
    .o_any(any_mismatch)
  );

  bmdi_cond u_cond (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_protected_mode(i_protected_mode),
    .i_host_restart(i_host_restart),
    .i_slave_mismatch(any_mismatch),
    .i_bus_power_fail(i_bus_power_fail),
    .i_eeprom_error(i_eeprom_error),
    .i_watchdog_fault(i_watchdog_fault),
    .cond_o(cif)
  );

  // ****************************************************************
  // Interrupt sequencing
  // ****************************************************************
  bmdi_pkg::bmdi_irq_state_t state;
  bmdi_pkg::bmdi_irq_state_t next_state;
  bmdi_pkg::bmdi_cond_t signalled;
  bmdi_pkg::bmdi_cond_t rec;
  logic rec_group;
  logic prot_q;
  logic [7:0] b8;
  logic [7:0] b9;
  logic [7:0] b10;
  logic [7:0] b11;
  logic [7:0] next_rdata;
  logic differs;
  logic ext_differs;
  logic can_raise;
  logic fire;
  logic cond_err;
  logic int_fault;
  logic ext_fault;
  logic to_config;

  assign int_fault = cif.cond.eeprom | cif.cond.wdog;
  assign ext_fault = cif.cond.mismatch | cif.cond.underv;
  assign cond_err = int_fault | ext_fault;
  // Watchdog is only reported, never a source; external bits count only when protected
  assign ext_differs = (cif.cond.mismatch != signalled.mismatch) |
                       (cif.cond.underv != signalled.underv);
  // State compare without watchdog: brief dropouts fold away while deferred
  assign differs = (cif.cond.eeprom != signalled.eeprom) |
                   (i_protected_mode & ext_differs);
  assign can_raise = i_host_run & (state == bmdi_pkg::BMDI_IDLE);
  assign fire = can_raise & differs;
  assign to_config = prot_q & ~i_protected_mode;

  always_comb begin
    next_state = state;
    case (state)
      bmdi_pkg::BMDI_IDLE: begin
        if (fire) begin
          next_state = bmdi_pkg::BMDI_PEND;
        end
      end
      bmdi_pkg::BMDI_PEND: begin
        if (i_host_ack || !i_host_run) begin
          next_state = bmdi_pkg::BMDI_IDLE;
        end
      end
      default: begin
        next_state = bmdi_pkg::BMDI_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= bmdi_pkg::BMDI_IDLE;
      prot_q <= 1'b0;
    end else begin
      state <= next_state;
      prot_q <= i_protected_mode;
    end
  end

  // History and record snapshot
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      signalled <= '0;
      rec <= '0;
      rec_group <= 1'b0;
    end else if (!i_host_run) begin
      signalled <= '0;
      rec <= '0;
      rec_group <= 1'b0;
    end else if (fire) begin
      signalled <= cif.cond;
      rec <= cif.cond;
      rec_group <= cond_err;
    end else if (to_config) begin
      signalled.mismatch <= 1'b0;
      signalled.underv <= 1'b0;
    end
  end

  // ****************************************************************
  // Short diagnostic record and outputs
  // ****************************************************************
  assign b8 = {3'b000, rec.underv, rec.mismatch, rec.mismatch | rec.underv,
               rec.eeprom | rec.wdog, rec_group};
  assign b9 = {1'b0, FW_V3 & i_slave_io_error, 1'b0, 1'b1, MODULE_CLASS};
  assign b10 = {4'h0, rec.wdog, i_offline, 1'b0, rec.mismatch};
  assign b11 = {5'h00, rec.eeprom, 2'b00};

  assign next_rdata = !i_rd ? `BMDI_RD_IDLE :
                      (i_addr == `BMDI_OFS_SUMMARY) ? b8 :
                      (i_addr == `BMDI_OFS_CLASS) ? b9 :
                      (i_addr == `BMDI_OFS_STATE) ? b10 :
                      (i_addr == `BMDI_OFS_MEMORY) ? b11 : `BMDI_RD_IDLE;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= `BMDI_RD_IDLE;
      o_diag_irq <= 1'b0;
      o_delta_list <= '0;
    end else begin
      o_rdata <= next_rdata;
      o_diag_irq <= (next_state == bmdi_pkg::BMDI_PEND);
      o_delta_list <= delta;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_irq_held;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (o_diag_irq && !i_host_ack && i_host_run) |=> o_diag_irq;
  endproperty
  a_irq_held: assert property (p_irq_held) else $error("irq dropped before ack");

  property p_fire_irq;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      fire |=> o_diag_irq;
  endproperty
  a_fire_irq: assert property (p_fire_irq) else $error("irq not raised on change");

  property p_no_same;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (can_raise && !differs) |=> !o_diag_irq;
  endproperty
  a_no_same: assert property (p_no_same) else $error("irq with unchanged state");

  property p_group;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      fire |=> (rec_group == $past(cond_err));
  endproperty
  a_group: assert property (p_group) else $error("group flag wrong");

  property p_stop_clear;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      !i_host_run |=> (rec == '0 && !rec_group && !o_diag_irq);
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("history not cleared");

  property p_b8_top;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_rd && i_addr == `BMDI_OFS_SUMMARY) |=> (o_rdata[7:5] == 3'b000);
  endproperty
  a_b8_top: assert property (p_b8_top) else $error("summary flags top bits set");

  property p_b9_one;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_rd && i_addr == `BMDI_OFS_CLASS) |=> (o_rdata[4] && o_rdata[3:0] == MODULE_CLASS);
  endproperty
  a_b9_one: assert property (p_b9_one) else $error("module class wrong");

  property p_b10;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_rd && i_addr == `BMDI_OFS_STATE) |=> (o_rdata[2] == $past(i_offline));
  endproperty
  a_b10: assert property (p_b10) else $error("offline bit wrong");

  property p_cfg_gate;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      !i_protected_mode |-> (!cif.cond.mismatch && !cif.cond.underv);
  endproperty
  a_cfg_gate: assert property (p_cfg_gate) else $error("external source in config mode");

  property p_ext_change;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_protected_mode && can_raise && cif.changed && ext_differs) |=> o_diag_irq;
  endproperty
  a_ext_change: assert property (p_ext_change) else $error("external change not signalled");

  property p_wdog_quiet;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (can_raise && cif.cond.wdog && !signalled.wdog && !ext_differs &&
       cif.cond.eeprom == signalled.eeprom) |=> !o_diag_irq;
  endproperty
  a_wdog_quiet: assert property (p_wdog_quiet) else $error("watchdog raised irq");

  property p_cfg_quiet;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (!i_protected_mode && can_raise && cif.cond.eeprom == signalled.eeprom) |=> !o_diag_irq;
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet) else $error("irq in config mode");

  property p_int_entering;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (fire && int_fault) |=> rec_group;
  endproperty
  a_int_entering: assert property (p_int_entering) else $error("internal fault not entering");

  property p_to_config;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      to_config |=> (!signalled.mismatch && !signalled.underv);
  endproperty
  a_to_config: assert property (p_to_config) else $error("external history kept");

  property p_cfg_to_prot;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_protected_mode && !prot_q && ext_fault && can_raise) |=> o_diag_irq;
  endproperty
  a_cfg_to_prot: assert property (p_cfg_to_prot) else $error("mode change irq missing");

  property p_b9_io;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_rd && i_addr == `BMDI_OFS_CLASS) |=> (o_rdata[6] == (FW_V3 & $past(i_slave_io_error)));
  endproperty
  a_b9_io: assert property (p_b9_io) else $error("slave io error bit wrong");

  property p_b9_resv;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_rd && i_addr == `BMDI_OFS_CLASS) |=> (!o_rdata[7] && !o_rdata[5]);
  endproperty
  a_b9_resv: assert property (p_b9_resv) else $error("module class reserved bits set");

  property p_b10_zero;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_rd && i_addr == `BMDI_OFS_STATE) |=> (o_rdata[7:4] == 4'h0 && !o_rdata[1]);
  endproperty
  a_b10_zero: assert property (p_b10_zero) else $error("state flags zero bits set");

  property p_b11;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_rd && i_addr == `BMDI_OFS_MEMORY) |=> (o_rdata[7:3] == 5'h00 && o_rdata[1:0] == 2'h0);
  endproperty
  a_b11: assert property (p_b11) else $error("memory flags zero bits set");
endmodule : bmdi_top
`default_nettype wire

/* bmdi_host_model.sv */
// Host processor model: reads the short record on interrupt, then acknowledges
`default_nettype none
module bmdi_host_model (
  input wire logic i_sys_clk,
  input wire logic i_irq,
  input wire logic [7:0] i_rdata,
  input wire logic i_hold,
  output logic o_rd,
  output logic [3:0] o_addr,
  output logic o_ack,
  output logic [39:0] o_rec,
  output var int o_n_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Handler
  // ********
  initial begin
    o_rd = 1'b0;
    o_addr = 4'h0;
    o_ack = 1'b0;
    o_rec = 40'h0;
    o_n_irq = 0;
    forever begin
      @(negedge i_sys_clk);
      if (i_irq === 1'b1) begin
        o_n_irq++;
        // Unmapped offset 7 first, so a stuck read bus shows up
        for (int a = 7; a < 13; a++) begin
          if (a > 7) o_rec = {o_rec[31:0], i_rdata};
          o_rd = (a < 12);
          o_addr = a[3:0];
          if (a < 12) @(negedge i_sys_clk);
        end
        // A slow handler keeps the request pending
        for (int w = 0; w < 200 && i_hold === 1'b1 && i_irq === 1'b1; w++) begin
          @(negedge i_sys_clk);
        end
        o_ack = 1'b1;
        @(negedge i_sys_clk);
        o_ack = 1'b0;
      end
    end
  end
endmodule : bmdi_host_model
`default_nettype wire

/* bmdi_top_tb_top.sv */
// Self-checking bench of the diagnostic interrupt block
`default_nettype none
module bmdi_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [39:0] PF = 40'h00_15_15_00_00;
  localparam logic [39:0] OK = 40'h00_00_15_00_00;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic prot = 1'b1, run = 1'b1, rst_req = 1'b0, offl = 1'b0, pf = 1'b0;
  logic eep = 1'b0, wdog = 1'b0, ioe = 1'b0, hold = 1'b0;
  logic [7:0] exp_map = 8'h0F, pres = 8'h0F, delta, rdata;
  logic rd, ack, irq;
  logic [3:0] addr;
  logic [39:0] rec;
  int n_irq, n_fail = 0, n_tests = 0;
  always #2 clk = ~clk;
  bmdi_top #(.N_SLAVES(8)) dut (.i_sys_clk(clk), .i_nrst(nrst),
    .i_protected_mode(prot), .i_host_run(run), .i_host_restart(rst_req),
    .i_host_ack(ack), .i_offline(offl), .i_bus_power_fail(pf),
    .i_eeprom_error(eep), .i_watchdog_fault(wdog), .i_slave_io_error(ioe),
    .i_expected(exp_map), .i_present(pres), .i_rd(rd), .i_addr(addr),
    .o_rdata(rdata), .o_diag_irq(irq), .o_delta_list(delta));
  bmdi_host_model host (.i_sys_clk(clk), .i_irq(irq), .i_rdata(rdata),
    .i_hold(hold), .o_rd(rd), .o_addr(addr), .o_ack(ack), .o_rec(rec),
    .o_n_irq(n_irq));
  // ********
  // Tasks
  // ********
  task automatic chk(input string what, input logic [39:0] e, input logic [39:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic results();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  // Waits for the handler count, then lets the record reads settle
  task automatic ev(input int cnt, input logic [39:0] e);
    int i;
    logic late;
    for (i = 0; i < 60 && n_irq != cnt; i++) @(negedge clk);
    late = (n_irq != cnt);
    repeat (12) @(negedge clk);
    chk("irq_count", 40'(cnt), 40'(n_irq));
    chk("record", e, rec);
    if (late) begin
      n_fail++;
      $display("mismatch irq_wait expected %0d seen %0d", cnt, n_irq);
      results();
    end
  endtask : ev
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  // ********
  // Sequence
  // ********
  initial begin
    idle(6);
    nrst = 1'b1;
    ev(0, 40'h0);
    pf = 1'b1;
    ev(1, PF);
    pf = 1'b0;
    ev(2, OK);
    offl = 1'b1;
    ioe = 1'b1;
    pres = 8'h07;
    ev(3, 40'h00_0D_55_05_00);
    chk("delta", 40'h08, 40'(delta));
    offl = 1'b0;
    ioe = 1'b0;
    pres = 8'h0F;
    ev(4, OK);
    hold = 1'b1;
    pf = 1'b1;
    ev(5, PF);
    chk("irq_held", 40'h1, 40'(irq));
    pres = 8'h07;
    idle(4);
    pres = 8'h0F;
    idle(4);
    hold = 1'b0;
    ev(5, PF);
    hold = 1'b1;
    pf = 1'b0;
    ev(6, OK);
    pf = 1'b1;
    idle(4);
    hold = 1'b0;
    ev(7, PF);
    prot = 1'b0;
    ev(7, PF);
    pf = 1'b0;
    idle(4);
    pf = 1'b1;
    ev(7, PF);
    prot = 1'b1;
    ev(8, PF);
    pf = 1'b0;
    ev(9, OK);
    run = 1'b0;
    prot = 1'b0;
    pres = 8'h07;
    idle(4);
    prot = 1'b1;
    idle(4);
    pres = 8'h0F;
    idle(4);
    run = 1'b1;
    ev(9, OK);
    hold = 1'b1;
    pf = 1'b1;
    ev(10, PF);
    run = 1'b0;
    idle(2);
    chk("irq_stop", 40'h0, 40'(irq));
    run = 1'b1;
    hold = 1'b0;
    ev(11, PF);
    pf = 1'b0;
    ev(12, OK);
    eep = 1'b1;
    wdog = 1'b1;
    idle(1);
    eep = 1'b0;
    wdog = 1'b0;
    // Faults gone again, yet no leaving request may follow
    ev(13, 40'h00_03_15_08_04);
    rst_req = 1'b1;
    idle(1);
    rst_req = 1'b0;
    // Restart frees the latched faults: exactly one leaving request
    ev(14, OK);
    wdog = 1'b1;
    idle(1);
    wdog = 1'b0;
    // Watchdog alone raises no request, so the record keeps its last value without the watchdog bit
    ev(14, OK);
    results();
  end
endmodule : bmdi_top_tb_top
`default_nettype wire
